// ### hw/tpb_pkg.sv
/*
  Shared constants of the timer pulse channel: register byte offsets,
  control and status bit positions, reset values and clock source codes.
  Assumes a 32-bit classic Wishbone bus with byte addressing.
*/
package tpb_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int CNT_W = 16;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0C;
  localparam logic [7:0] OFS_CAPCMP = 8'h10;
  localparam logic [7:0] OFS_BUFFER = 8'h14;

  ////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_W        = 9;
  localparam int CB_STOP       = 0;
  localparam int CB_CLEAR_EN   = 1;
  localparam int CB_CAPTURE    = 2;
  localparam int CB_BUFFER_EN  = 3;
  localparam int CB_OUT_EN     = 4;
  localparam int CB_CLK_LO     = 5;
  localparam int CB_CLK_HI     = 6;
  localparam int CB_DOWN       = 7;
  localparam int CB_XFER_EN    = 8;
  localparam logic [8:0] CTRL_RESET = 9'h001;

  ////////////////////////////////////////////////////////////////////////
  // Status and interrupt enable fields
  localparam int ST_W   = 3;
  localparam int SB_MCF = 0;
  localparam int SB_OVF = 1;
  localparam int SB_UNF = 2;
  localparam logic [2:0] ST_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // Count clock sources
  localparam logic [1:0] CLK_INTERNAL = 2'h0;
  localparam logic [1:0] CLK_EXT_RISE = 2'h1;
  localparam logic [1:0] CLK_EXT_BOTH = 2'h2;
  localparam logic [1:0] CLK_PHASE    = 2'h3;

  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

endpackage

// ### hw/tpb_clock_decode.sv
/*
  Count clock decoder: turns the selected count source into one-cycle
  up and down ticks. Assumes the external inputs are synchronous to the
  system clock and meet the pulse width limits of the source.
*/
`timescale 1ns/10ps
module tpb_clock_decode (
  // Clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_ce,
  // Source selection
  input  wire logic [1:0] i_sel,
  input  wire logic       i_down,
  // External count inputs
  input  wire logic       i_ext_a,
  input  wire logic       i_ext_b,
  // Ticks
  output logic            o_up,
  output logic            o_dn
);

  logic a_d_r;
  logic b_d_r;
  logic any_chg;

  ////////////////////////////////////////////////////////////////////////
  // Previous levels
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      a_d_r <= 1'b0;
      b_d_r <= 1'b0;
    end else if (i_ce) begin
      a_d_r <= i_ext_a;
      b_d_r <= i_ext_b;
    end
  end

  assign any_chg = (i_ext_a ^ a_d_r) | (i_ext_b ^ b_d_r);

  ////////////////////////////////////////////////////////////////////////
  // Tick generation
  always_comb begin
    o_up = 1'b0;
    o_dn = 1'b0;
    case (i_sel)
      tpb_pkg::CLK_INTERNAL: begin
        o_up = !i_down;
        o_dn = i_down;
      end
      tpb_pkg::CLK_EXT_RISE: begin
        o_up = !i_down & i_ext_a & !a_d_r;
        o_dn = i_down & i_ext_a & !a_d_r;
      end
      tpb_pkg::CLK_EXT_BOTH: begin
        o_up = !i_down & (i_ext_a ^ a_d_r);
        o_dn = i_down & (i_ext_a ^ a_d_r);
      end
      tpb_pkg::CLK_PHASE: begin
        o_up = any_chg & (i_ext_a ^ b_d_r);
        o_dn = any_chg & !(i_ext_a ^ b_d_r);
      end
      default: begin
        o_up = 1'b0;
        o_dn = 1'b0;
      end
    endcase
  end

endmodule

// ### hw/tpb_timer_channel.sv
/*
  One timer pulse channel with counter, capture/compare and buffer
  registers, contention priorities and a classic Wishbone slave.
  Assumes a single-cycle Wishbone master and synchronous pin inputs.
*/
//
// Summary of operation
// - Stopped after reset until stop bit cleared
// - Clear on last matching state, period N+1
// - Clear beats counter write in second state
// - Counter write beats increment in second state
// - Compare register write suppresses that match
// - Buffer transfer uses buffer before write
// - Capture in first state reads new value
// - Capture beats compare register write
// - Capture buffer transfer beats buffer write
// - Clear suppresses overflow and underflow flags
// - Counter write suppresses overflow/underflow flags
// - Flags frozen while stopped; disable interrupts first
// - Clear flag by zero after one read
// - Interrupt while flag and enable set
`timescale 1ns/10ps
module tpb_timer_channel (
  // Clock, reset, enable
  input  wire logic        I_CLK,
  input  wire logic        I_RESETN,
  input  wire logic        I_CE,
  // Wishbone slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  // Timer pins
  input  wire logic        I_EXT_CLOCK_A,
  input  wire logic        I_EXT_CLOCK_B,
  input  wire logic        I_CAPTURE_PIN,
  output logic             O_COMPARE_OUT,
  output logic             O_COMPARE_OE,
  // Interrupt and transfer controller
  output logic             O_IRQ,
  output logic             O_XFER_REQ,
  input  wire logic        I_XFER_ACK
);

  typedef enum logic {TPB_BUS_IDLE, TPB_BUS_T2} tpb_bus_t;

  tpb_bus_t    state_r;
  logic [8:0]  ctrl_r;
  logic [8:0]  ctrl_nxt;
  logic [2:0]  irq_en_r;
  logic [2:0]  irq_en_nxt;
  logic [2:0]  status_r;
  logic [2:0]  status_nxt;
  logic [2:0]  seen_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] capcmp_r;
  logic [15:0] capcmp_nxt;
  logic [15:0] buffer_r;
  logic [15:0] buffer_nxt;
  logic        cap_d_r;
  logic        acc_t1;
  logic        acc_t2;
  logic        run;
  logic        tick_up;
  logic        tick_dn;
  logic        ev_up;
  logic        ev_dn;
  logic        wr_ctrl;
  logic        wr_irq_en;
  logic        wr_status;
  logic        wr_count;
  logic        wr_capcmp;
  logic        wr_buffer;
  logic        match_now;
  logic        capture_ev;
  logic        clear_ev;
  logic        ovf_ev;
  logic        unf_ev;
  logic [15:0] wval_count;
  logic [15:0] wval_capcmp;
  logic [15:0] wval_buffer;
  logic [31:0] rd_data;
  logic [2:0]  st_clr;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? wd[15:8] : old[15:8],
               sel[0] ? wd[7:0]  : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus cycle states
  assign acc_t1 = (state_r == TPB_BUS_IDLE) & I_WB_CYC & I_WB_STB;
  assign acc_t2 = (state_r == TPB_BUS_T2);

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      state_r  <= TPB_BUS_IDLE;
      O_WB_ACK <= 1'b0;
    end else if (I_CE) begin
      case (state_r)
        TPB_BUS_IDLE: begin
          if (acc_t1) begin
            state_r  <= TPB_BUS_T2;
            O_WB_ACK <= 1'b1;
          end
        end
        TPB_BUS_T2: begin
          state_r  <= TPB_BUS_IDLE;
          O_WB_ACK <= 1'b0;
        end
        default: begin
          state_r  <= TPB_BUS_IDLE;
          O_WB_ACK <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write decode, only control while stopped
  assign run       = !ctrl_r[tpb_pkg::CB_STOP];
  assign wr_ctrl   = acc_t2 & I_WB_WE & hit(I_WB_ADR, tpb_pkg::OFS_CTRL);
  assign wr_irq_en = acc_t2 & I_WB_WE & run
                     & hit(I_WB_ADR, tpb_pkg::OFS_IRQ_EN);
  assign wr_status = acc_t2 & I_WB_WE & run
                     & hit(I_WB_ADR, tpb_pkg::OFS_STATUS);
  assign wr_count  = acc_t2 & I_WB_WE & run
                     & hit(I_WB_ADR, tpb_pkg::OFS_COUNT);
  assign wr_capcmp = acc_t2 & I_WB_WE & run
                     & hit(I_WB_ADR, tpb_pkg::OFS_CAPCMP);
  assign wr_buffer = acc_t2 & I_WB_WE & run
                     & hit(I_WB_ADR, tpb_pkg::OFS_BUFFER);

  assign wval_count  = merge16(count_r, I_WB_DAT, I_WB_SEL);
  assign wval_capcmp = merge16(capcmp_r, I_WB_DAT, I_WB_SEL);
  assign wval_buffer = merge16(buffer_r, I_WB_DAT, I_WB_SEL);

  ////////////////////////////////////////////////////////////////////////
  // Count source
  tpb_clock_decode u_clock_decode (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_ce     (I_CE),
    .i_sel    (ctrl_r[tpb_pkg::CB_CLK_HI:tpb_pkg::CB_CLK_LO]),
    .i_down   (ctrl_r[tpb_pkg::CB_DOWN]),
    .i_ext_a  (I_EXT_CLOCK_A),
    .i_ext_b  (I_EXT_CLOCK_B),
    .o_up     (tick_up),
    .o_dn     (tick_dn)
  );

  ////////////////////////////////////////////////////////////////////////
  // Timer events
  assign ev_up      = run & tick_up;
  assign ev_dn      = run & tick_dn;
  assign capture_ev = run & ctrl_r[tpb_pkg::CB_CAPTURE]
                      & I_CAPTURE_PIN & !cap_d_r;
  assign match_now  = !ctrl_r[tpb_pkg::CB_CAPTURE] & (ev_up | ev_dn)
                      & (count_r == capcmp_r) & !wr_capcmp;
  assign clear_ev   = ctrl_r[tpb_pkg::CB_CLEAR_EN]
                      & (ctrl_r[tpb_pkg::CB_CAPTURE] ? capture_ev
                                                     : match_now);
  assign ovf_ev     = ev_up & (count_r == tpb_pkg::CNT_MAX);
  assign unf_ev     = ev_dn & (count_r == tpb_pkg::CNT_ZERO);

  ////////////////////////////////////////////////////////////////////////
  // Next values
  always_comb begin
    ctrl_nxt = wr_ctrl ? I_WB_DAT[8:0] : ctrl_r;
    irq_en_nxt = wr_irq_en ? I_WB_DAT[2:0] : irq_en_r;
    if (clear_ev) begin
      count_nxt = tpb_pkg::CNT_ZERO;
    end else if (wr_count) begin
      count_nxt = wval_count;
    end else if (ev_up) begin
      count_nxt = count_r + tpb_pkg::CNT_ONE;
    end else if (ev_dn) begin
      count_nxt = count_r - tpb_pkg::CNT_ONE;
    end else begin
      count_nxt = count_r;
    end
    if (capture_ev) begin
      capcmp_nxt = count_r;
    end else if (wr_capcmp) begin
      capcmp_nxt = wval_capcmp;
    end else if (match_now & ctrl_r[tpb_pkg::CB_BUFFER_EN]) begin
      capcmp_nxt = buffer_r;
    end else begin
      capcmp_nxt = capcmp_r;
    end
    if (capture_ev & ctrl_r[tpb_pkg::CB_BUFFER_EN]) begin
      buffer_nxt = capcmp_r;
    end else if (wr_buffer) begin
      buffer_nxt = wval_buffer;
    end else begin
      buffer_nxt = buffer_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags, set wins over clear
  always_comb begin
    st_clr = 3'h0;
    if (wr_status) begin
      st_clr = seen_r & ~I_WB_DAT[2:0];
    end
    if (run & I_XFER_ACK & ctrl_r[tpb_pkg::CB_XFER_EN]) begin
      st_clr[tpb_pkg::SB_MCF] = 1'b1;
    end
    status_nxt = status_r & ~st_clr;
    if (match_now | capture_ev) begin
      status_nxt[tpb_pkg::SB_MCF] = 1'b1;
    end
    if (ovf_ev & !clear_ev & !wr_count) begin
      status_nxt[tpb_pkg::SB_OVF] = 1'b1;
    end
    if (unf_ev & !clear_ev & !wr_count) begin
      status_nxt[tpb_pkg::SB_UNF] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux from next values
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit(I_WB_ADR, tpb_pkg::OFS_CTRL)) begin
      rd_data[8:0] = ctrl_r;
    end else if (run) begin
      if (hit(I_WB_ADR, tpb_pkg::OFS_IRQ_EN)) begin
        rd_data[2:0] = irq_en_r;
      end else if (hit(I_WB_ADR, tpb_pkg::OFS_STATUS)) begin
        rd_data[2:0] = status_nxt;
      end else if (hit(I_WB_ADR, tpb_pkg::OFS_COUNT)) begin
        rd_data[15:0] = count_nxt;
      end else if (hit(I_WB_ADR, tpb_pkg::OFS_CAPCMP)) begin
        rd_data[15:0] = capcmp_nxt;
      end else if (hit(I_WB_ADR, tpb_pkg::OFS_BUFFER)) begin
        rd_data[15:0] = buffer_nxt;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_WB_DAT <= 32'h0000_0000;
    end else if (I_CE & acc_t1 & !I_WB_WE) begin
      O_WB_DAT <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register state
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      ctrl_r   <= tpb_pkg::CTRL_RESET;
      irq_en_r <= tpb_pkg::ST_RESET;
      count_r  <= tpb_pkg::CNT_ZERO;
      capcmp_r <= tpb_pkg::CNT_MAX;
      buffer_r <= tpb_pkg::CNT_MAX;
      cap_d_r  <= 1'b0;
    end else if (I_CE) begin
      ctrl_r   <= ctrl_nxt;
      irq_en_r <= irq_en_nxt;
      count_r  <= count_nxt;
      capcmp_r <= capcmp_nxt;
      buffer_r <= buffer_nxt;
      cap_d_r  <= I_CAPTURE_PIN;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      status_r <= tpb_pkg::ST_RESET;
      seen_r   <= tpb_pkg::ST_RESET;
    end else if (I_CE) begin
      status_r <= status_nxt;
      if (acc_t1 & !I_WB_WE & run & hit(I_WB_ADR, tpb_pkg::OFS_STATUS)) begin
        seen_r <= status_nxt;
      end else begin
        seen_r <= seen_r & status_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt, transfer request and compare pin
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_IRQ         <= 1'b0;
      O_XFER_REQ    <= 1'b0;
      O_COMPARE_OUT <= 1'b0;
      O_COMPARE_OE  <= 1'b0;
    end else if (I_CE) begin
      O_IRQ         <= |(status_nxt & irq_en_nxt);
      O_XFER_REQ    <= status_nxt[tpb_pkg::SB_MCF]
                       & ctrl_nxt[tpb_pkg::CB_XFER_EN];
      O_COMPARE_OE  <= ctrl_nxt[tpb_pkg::CB_OUT_EN]
                       & !ctrl_nxt[tpb_pkg::CB_CAPTURE];
      if (match_now) begin
        O_COMPARE_OUT <= !O_COMPARE_OUT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);

  a_stop_count_freeze: assert property (
    I_CE & !run |=> $stable(count_r)) else $error("count moved in stop");
  a_match_clear_zero: assert property (
    I_CE & match_now & ctrl_r[tpb_pkg::CB_CLEAR_EN] |=> count_r == 16'h0000)
    else $error("no clear on match");
  a_clear_beats_write: assert property (
    I_CE & clear_ev & wr_count |=> count_r == 16'h0000)
    else $error("write beat clear");
  a_write_beats_inc: assert property (
    I_CE & wr_count & ev_up & !clear_ev |=> count_r == $past(wval_count))
    else $error("increment beat write");
  a_write_no_match: assert property (
    I_CE & wr_capcmp & (ev_up | ev_dn) & (count_r == capcmp_r)
    & !status_r[tpb_pkg::SB_MCF] & !capture_ev
    |=> !status_r[tpb_pkg::SB_MCF]) else $error("match during write");
  a_buffer_old_value: assert property (
    I_CE & match_now & ctrl_r[tpb_pkg::CB_BUFFER_EN] & wr_buffer
    |=> capcmp_r == $past(buffer_r)) else $error("new buffer transferred");
  a_read_new_capture: assert property (
    I_CE & acc_t1 & !I_WB_WE & hit(I_WB_ADR, tpb_pkg::OFS_CAPCMP)
    & capture_ev |=> O_WB_DAT[15:0] == capcmp_r)
    else $error("stale capture read");
  a_capture_beats_write: assert property (
    I_CE & capture_ev & wr_capcmp |=> capcmp_r == $past(count_r))
    else $error("write beat capture");
  a_capture_buf_wins: assert property (
    I_CE & capture_ev & ctrl_r[tpb_pkg::CB_BUFFER_EN] & wr_buffer
    |=> buffer_r == $past(capcmp_r)) else $error("buffer write won");
  a_ovf_clear_none: assert property (
    I_CE & (ovf_ev | unf_ev) & (clear_ev | wr_count) & (status_r[2:1] == 2'h0)
    |=> status_r[2:1] == 2'h0)
    else $error("flag set under clear or write");
  a_irq_follows_flag: assert property (
    I_CE |=> O_IRQ == |(status_r & irq_en_r)) else $error("irq mismatch");
  a_ack_second_state: assert property (
    I_CE & acc_t1 |=> O_WB_ACK ##1 (!O_WB_ACK | !$past(I_CE)))
    else $error("ack timing");

  c_match_clear: cover property (I_CE & match_now & clear_ev);
  c_capture_read: cover property (I_CE & capture_ev & acc_t1);
  c_overflow: cover property (I_CE & ovf_ev ##1 O_IRQ);
  c_status_clear: cover property (I_CE & wr_status & (st_clr != 3'h0));

endmodule

// ### testbench/tpb_xfer_partner.sv
/*
  Transfer controller model: answers a request with a one-cycle ack,
  at once or after a stall.
  Assumes the request stays high until its ack has been taken.
*/
`timescale 1ns/10ps
module tpb_xfer_partner (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Request side
  input  wire logic i_req,
  input  wire logic i_slow,
  output logic      o_ack
);
  logic [3:0] wait_r;

  // One ack per request, prompt or late
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_req) begin
      wait_r <= 4'h0;
      o_ack  <= 1'b0;
    end else begin
      wait_r <= (wait_r == 4'hF) ? wait_r : wait_r + 4'h1;
      o_ack  <= (wait_r == (i_slow ? 4'h5 : 4'h0));
    end
  end
endmodule

// ### testbench/tb_timer_access_contention.sv
/*
  Self-checking bench of the timer channel: counting sources, period,
  flags, interrupt, bus contention and transfer handshake.
  Assumes the one-cycle Wishbone answer and register map of the channel.
*/
`timescale 1ns/10ps
module tb_timer_access_contention;
  logic        clk, resetn, cyc, stb, we, ack;
  logic        ext_a, ext_b, cap_pin, cmp_out, cmp_oe;
  logic        irq, xreq, xack, slow;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [31:0] exp_q[$];
  logic [15:0] c, p;
  int          fail_count, n_tests, g, n;
  logic [31:0] rb[3] = '{32'h0000_0002, 32'h0000_0000, 32'h0000_0080};
  logic [15:0] rc[3] = '{16'hFFFF, 16'h8000, 16'h8000};
  logic [15:0] rs[3] = '{16'hFFF0, 16'hFFF0, 16'h0008};
  logic [31:0] re[3] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0004};
  logic [31:0] kb[4] = '{32'h0000_0002, 32'h0000_0000, 32'h0000_0008,
                         32'h0000_0000};
  logic [15:0] ks[4] = '{16'h0006, 16'h0006, 16'h0006, 16'hFFFD};
  logic [7:0]  ka[4] = '{tpb_pkg::OFS_COUNT, tpb_pkg::OFS_CAPCMP,
                         tpb_pkg::OFS_BUFFER, tpb_pkg::OFS_COUNT};
  logic [15:0] kw[4] = '{16'h0100, 16'h0008, 16'h00AA, 16'h0010};
  logic [7:0]  kr[4] = '{tpb_pkg::OFS_COUNT, tpb_pkg::OFS_COUNT,
                         tpb_pkg::OFS_CAPCMP, tpb_pkg::OFS_COUNT};
  logic [15:0] kx[4] = '{16'h0003, 16'h000C, 16'h0055, 16'h0013};
  logic [31:0] ke[4] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0001,
                         32'h0000_0000};

  always #50 clk = ~clk;

  tpb_timer_channel u_tpb_timer_channel (
    .I_CLK(clk), .I_RESETN(resetn), .I_CE(1'b1),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_EXT_CLOCK_A(ext_a), .I_EXT_CLOCK_B(ext_b),
    .I_CAPTURE_PIN(cap_pin), .O_COMPARE_OUT(cmp_out),
    .O_COMPARE_OE(cmp_oe), .O_IRQ(irq), .O_XFER_REQ(xreq),
    .I_XFER_ACK(xack));

  tpb_xfer_partner u_tpb_xfer_partner (
    .i_clk(clk), .i_resetn(resetn), .i_req(xreq), .i_slow(slow),
    .o_ack(xack));

  //////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, v);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tmo(string nm);
    fail_count++;
    $display("MISMATCH %s expected done seen timeout", nm);
    end_sim();
  endtask

  // Classic cycle; cap raises the capture pin in state 1 or 2
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, int cap);
    int i;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'h3;
    if (cap == 1) cap_pin <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (cap == 2 && i == 0) cap_pin <= 1'b1;
      if (ack === 1'b1) break;
    end
    if (i == 20) tmo("bus ack");
    cyc     <= 1'b0;
    stb     <= 1'b0;
    cap_pin <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d, 0);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, int cap);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000, cap);
  endtask

  function automatic logic [31:0] ctl(logic [1:0] s, logic [31:0] b);
    return b | (32'(s) << tpb_pkg::CB_CLK_LO);
  endfunction

  // External source selected but idle: counter holds still
  function automatic logic [31:0] hlt(logic [31:0] b);
    return ctl(tpb_pkg::CLK_EXT_RISE, b);
  endfunction

  // Quadrature periods, each state held 3 cycles
  task automatic ext_run(int np);
    for (int k = 0; k < 4 * np; k++) begin
      @(posedge clk);
      ext_a <= (k % 4) < 2;
      ext_b <= (k % 4) == 1 || (k % 4) == 2;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic gap(output int gg);
    logic t;
    t = cmp_out;
    for (gg = 1; gg < 100; gg++) begin
      @(posedge clk);
      if (cmp_out !== t) return;
    end
    tmo("compare toggle");
  endtask

  task automatic wait_req(logic v);
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      if (xreq === v) return;
    end
    tmo("transfer request");
  endtask

  task automatic done(string nm);
    $display("test %s done", nm);
  endtask

  // Read results taken off the queue as each read ack appears
  always @(posedge clk) begin
    if (ack === 1'b1 && !we) begin
      if (exp_q.size() == 0) chk("read queue", 32'h0, rdat);
      else chk("read data", exp_q.pop_front(), rdat);
    end
  end

  //////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h5435));
    {clk, resetn, cyc, stb, we, ext_a, ext_b, cap_pin, slow} = '0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    fail_count = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("irq", 32'h0, 32'(irq));
    chk("xfer request", 32'h0, 32'(xreq));
    rd(tpb_pkg::OFS_CTRL, 32'h0000_0001, 0);
    wr(tpb_pkg::OFS_COUNT, 32'h0000_1234);
    rd(tpb_pkg::OFS_COUNT, 32'h0000_0000, 0);
    rd(8'h20, 32'h0000_0000, 0);
    done("reset");
    // Each external source counts 3 quadrature periods; no compare output
    for (int s = 1; s < 4; s++) begin
      wr(tpb_pkg::OFS_CTRL, ctl(2'(s), 32'h0000_0000));
      wr(tpb_pkg::OFS_COUNT, 32'h0000_0000);
      ext_run(3);
      rd(tpb_pkg::OFS_COUNT, 32'(3 << (s - 1)), 0);
    end
    done("count sources");
    c = 16'($urandom()) & 16'h7FFF;
    wr(tpb_pkg::OFS_CTRL, ctl(tpb_pkg::CLK_INTERNAL, 32'h0000_0000));
    wr(tpb_pkg::OFS_COUNT, 32'(c));
    rd(tpb_pkg::OFS_COUNT, 32'(c + 16'h0002), 0);
    done("write versus increment");
    n = 3 + ($urandom() % 6);
    wr(tpb_pkg::OFS_CTRL, hlt(32'h0000_0000));
    wr(tpb_pkg::OFS_CAPCMP, 32'(n));
    wr(tpb_pkg::OFS_COUNT, 32'h0000_0000);
    wr(tpb_pkg::OFS_IRQ_EN, 32'h0000_0001);
    wr(tpb_pkg::OFS_CTRL, ctl(tpb_pkg::CLK_INTERNAL, 32'h0000_0012));
    gap(g);
    gap(g);
    chk("period", 32'(n + 1), 32'(g));
    chk("compare oe", 32'h1, 32'(cmp_oe));
    chk("irq", 32'h1, 32'(irq));
    wr(tpb_pkg::OFS_CTRL, hlt(32'h0000_0002));
    rd(tpb_pkg::OFS_STATUS, 32'h0000_0001, 0);
    wr(tpb_pkg::OFS_STATUS, 32'h0000_0000);
    done("period");
    for (int r = 0; r < 3; r++) begin
      wr(tpb_pkg::OFS_CTRL, hlt(rb[r]));
      wr(tpb_pkg::OFS_CAPCMP, 32'(rc[r]));
      wr(tpb_pkg::OFS_COUNT, 32'(rs[r]));
      wr(tpb_pkg::OFS_CTRL, ctl(tpb_pkg::CLK_INTERNAL, rb[r]));
      repeat (40) @(posedge clk);
      wr(tpb_pkg::OFS_CTRL, hlt(rb[r]));
      rd(tpb_pkg::OFS_STATUS, re[r], 0);
      wr(tpb_pkg::OFS_STATUS, 32'h0000_0000);
    end
    done("overflow and clear");
    // Second state of a write meets clear, match, buffer move, overflow
    wr(tpb_pkg::OFS_BUFFER, 32'h0000_0055);
    for (int r = 0; r < 4; r++) begin
      wr(tpb_pkg::OFS_CTRL, hlt(kb[r]));
      wr(tpb_pkg::OFS_CAPCMP, 32'h0000_0008);
      wr(tpb_pkg::OFS_COUNT, 32'(ks[r]));
      wr(tpb_pkg::OFS_CTRL, ctl(tpb_pkg::CLK_INTERNAL, kb[r]));
      wr(ka[r], 32'(kw[r]));
      wr(tpb_pkg::OFS_CTRL, hlt(kb[r]));
      rd(kr[r], 32'(kx[r]), 0);
      rd(tpb_pkg::OFS_STATUS, ke[r], 0);
      wr(tpb_pkg::OFS_STATUS, 32'h0000_0000);
    end
    done("write contention");
    c = 16'($urandom());
    p = c ^ 16'h00FF;
    wr(tpb_pkg::OFS_CTRL, hlt(32'h0000_0004));
    wr(tpb_pkg::OFS_COUNT, 32'(c));
    wr(tpb_pkg::OFS_CAPCMP, 32'(p));
    rd(tpb_pkg::OFS_CAPCMP, 32'(p), 0);
    rd(tpb_pkg::OFS_CAPCMP, 32'(c), 1);
    bus(1'b1, tpb_pkg::OFS_CAPCMP, 32'(~c), 2);
    rd(tpb_pkg::OFS_CAPCMP, 32'(c), 0);
    wr(tpb_pkg::OFS_CTRL, hlt(32'h0000_000C));
    wr(tpb_pkg::OFS_COUNT, 32'(p));
    bus(1'b1, tpb_pkg::OFS_BUFFER, 32'(~p), 2);
    rd(tpb_pkg::OFS_BUFFER, 32'(c), 0);
    rd(tpb_pkg::OFS_CAPCMP, 32'(p), 0);
    done("capture contention");
    wr(tpb_pkg::OFS_IRQ_EN, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, 32'(irq));
    wr(tpb_pkg::OFS_IRQ_EN, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, 32'(irq));
    rd(tpb_pkg::OFS_STATUS, 32'h0000_0001, 0);
    wr(tpb_pkg::OFS_STATUS, 32'h0000_0001);
    rd(tpb_pkg::OFS_STATUS, 32'h0000_0001, 0);
    wr(tpb_pkg::OFS_STATUS, 32'h0000_0000);
    rd(tpb_pkg::OFS_STATUS, 32'h0000_0000, 0);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, 32'(irq));
    done("interrupt");
    for (int s = 0; s < 2; s++) begin
      slow <= 1'(s);
      wr(tpb_pkg::OFS_CTRL, hlt(32'h0000_0104));
      rd(tpb_pkg::OFS_CAPCMP, 32'(p), 1);
      wait_req(1'b1);
      wait_req(1'b0);
      rd(tpb_pkg::OFS_STATUS, 32'h0000_0000, 0);
    end
    done("transfer");
    @(posedge clk);
    end_sim();
  end
endmodule
